// file: bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic       clk, srst, fg, fr, we, po, pr;
  logic [7:0] ad, wd, rdat, v;
  int         bad_count = 0, n_checks = 0, cyc = 0;
  // Short base count: intervals become 10/20/40/80 cycles
  wdt_top #(.BASE_CYC(40'h0a)) dut (.clk(clk), .srst(srst), .factory_guard(fg), .factory_run(fr),
    .reg_addr(ad), .reg_wr(we), .reg_wdata(wd), .reg_rdata(rdat), .power_off_req(po), .power_reset_req(pr));
  wdt_host host (.clk(clk), .reg_addr(ad), .reg_wr(we), .reg_wdata(wd), .reg_rdata(rdat));
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s exp %h seen %h", s, exp, seen);
    end
  endtask : chk
  // Reset with given factory values, held 20 cycles
  task automatic rst(input logic g, input logic r);
    fg = g;
    fr = r;
    srst = 1'b1;
    repeat (20) @(posedge clk);
    #1 srst = 1'b0;
  endtask : rst
  // Wait for a request; k=0 expects none. Window allows for the read and register delays
  task automatic pulse(input int n, input logic [1:0] k);
    int c;
    c = 0;
    while (!(po | pr) && c < n + 4) begin
      @(posedge clk) #1;
      c++;
    end
    if (k != 2'h0) chk("gap", 8'(c >= n - 4 && c <= n + 3), 8'h01);
    chk("req", {6'h0, pr, po}, {6'h0, k});
  endtask : pulse
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  // Main sequence
  initial begin
    rst(1'b0, 1'b0);
    host.rd(8'h17, v);
    chk("reset", v, 8'h30);
    pulse(100, 2'h0);
    // Every period code, alternating the expiry action
    for (int p = 0; p < 4; p++) begin
      host.wr(8'h17, 8'(p * 16 + p % 2 * 8 + 2));
      host.rd(8'h17, v);
      chk("cfg", v, 8'(p * 16 + p % 2 * 8 + 2));
      pulse(10 << p, 2'(1 + p % 2));
    end
    host.wr(8'h17, 8'h02);
    repeat (7) @(posedge clk);
    host.wr(8'h17, 8'h06);
    host.rd(8'h17, v);
    chk("feed", v, 8'h02);
    pulse(10, 2'h1);
    host.wr(8'h17, 8'h00);
    pulse(100, 2'h0);
    rst(1'b1, 1'b1);
    host.rd(8'h17, v);
    chk("guard", v, 8'h33);
    pulse(80, 2'h1);
    host.wr(8'h17, 8'h00);
    host.rd(8'h17, v);
    chk("lock", v, 8'h03);
    pulse(10, 2'h1);
    host.wr(8'h16, 8'h3e);
    host.rd(8'h17, v);
    chk("other", v, 8'h03);
    host.rd(8'h16, v);
    chk("unmap", v, 8'h00);
    wrap_up();
  end
endmodule : tb
`default_nettype wire

// file: bench/wdt_host.sv
`timescale 1ns/10ps
`default_nettype none
// Host software on the serial side, one register access at a time
module wdt_host (
  // Clock
  input  wire logic       clk,
  // Register port
  output logic [7:0]      reg_addr,
  output logic            reg_wr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // Idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  // One write; after release the lines show the inverse, not stale data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    reg_addr = a;
    reg_wdata = {2'h0, d[5:0]};
    reg_wr = 1'b1;
    @(posedge clk) #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  // Read data is combinational, so sample once the address has settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) #1;
    reg_addr = a;
    #2 d = reg_rdata;
  endtask : rd
endmodule : wdt_host
`default_nettype wire

// file: inc/wdt_cfg_if.sv
`timescale 1ns/10ps
`default_nettype none
// Settings handed from the register to the countdown
interface wdt_cfg_if;
  logic [1:0] period_sel;
  logic       run;
  logic       reload;
  logic       expired;
  modport regs (output period_sel, output run, output reload, input expired);
  modport cnt  (input period_sel, input run, input reload, output expired);
endinterface : wdt_cfg_if
`default_nettype wire

// file: inc/wdt_map.svh
// Overview of operation
// - Period field picks 16/32/64/128 s, reset 128
// - Changing period reloads countdown immediately
// - Expiry requests power-off, or power-reset when set
// - Writing feed one restarts full interval
// - Timer counts only while run bit set
// - Guard set: clearing run bit ignored
// - Guard clear: run bit freely set/cleared
// - Guard read-only factory value; run reset factory
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH
`define WDT_CFG_ADDR      8'h17
`define TIMEOUT_PERIOD_SEL_HI        5
`define TIMEOUT_PERIOD_SEL_LO        4
`define WDT_ACT_BIT       3
`define WDT_FEED_BIT      2
`define WDT_RUN_BIT       1
`define WDT_GUARD_BIT     0
`define TIMEOUT_PERIOD_SEL_RESET     2'h3
`define WDT_ACT_RESET     1'h0
`define WDT_BASE_SEC      16
`define WDT_CLK_HZ        100000000
`define WDT_BASE_CYC      (`WDT_BASE_SEC * `WDT_CLK_HZ)
`endif

// file: inc/wdt_pkg.sv
package wdt_pkg;
  typedef enum logic [1:0] {
    WDT_ACT_OFF   = 2'h1,
    WDT_ACT_RESET = 2'h2
  } wdt_action_t;
endpackage : wdt_pkg

// file: logic/wdt_counter.sv
`timescale 1ns/10ps
`default_nettype none
`include "wdt_map.svh"
module wdt_counter
  import wdt_pkg::*;
#(
  parameter logic [39:0] BASE_CYC = 40'(`WDT_BASE_CYC)
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Settings
  wdt_cfg_if.cnt    cfg
);
  logic [39:0] remain;
  logic [39:0] full;

  // Interval scales 16 s by a power of two
  assign full = BASE_CYC << cfg.period_sel;

  // Countdown; a reload always wins over counting
  always_ff @(posedge clk) begin
    if (srst) begin
      // Start loaded: a factory-enabled timer must not expire at once
      remain      <= full;
      cfg.expired <= 1'b0;
    end else if (cfg.reload || !cfg.run) begin
      remain      <= full;
      cfg.expired <= 1'b0;
    end else if (remain <= 40'h1) begin
      remain      <= full;
      cfg.expired <= 1'b1;
    end else begin
      remain      <= remain - 40'h1;
      cfg.expired <= 1'b0;
    end
  end

  // An expiry pulse needs a running timer
  property p_expire_needs_run;
    @(posedge clk) disable iff (srst) cfg.expired |-> $past(cfg.run) && !$past(cfg.reload);
  endproperty
  a_expire_needs_run: assert property (p_expire_needs_run) else $error("expiry while stopped");
endmodule : wdt_counter
`default_nettype wire

// file: logic/wdt_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "wdt_map.svh"
module wdt_top
  import wdt_pkg::*;
#(
  parameter logic [39:0] BASE_CYC = 40'(`WDT_BASE_CYC)
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // Factory configuration
  input  wire logic       factory_guard,
  input  wire logic       factory_run,
  // Register port from the serial interface
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  // Requests to the on/off controller
  output logic            power_off_req,
  output logic            power_reset_req
);
  wdt_cfg_if cfg ();
  logic [1:0] timeout_period_sel;
  logic       expiry_action_sel;
  logic       feed_strobe;
  logic       timer_run_bit;
  logic       disable_guard_bit;
  logic       hit;
  wdt_action_t action;

  assign hit = reg_wr && (reg_addr == `WDT_CFG_ADDR);

  // Guard bit captured from factory value, never written
  always_ff @(posedge clk) begin
    if (srst) disable_guard_bit <= factory_guard;
  end

  // Period and action fields
  always_ff @(posedge clk) begin
    if (srst) begin
      timeout_period_sel <= `TIMEOUT_PERIOD_SEL_RESET;
      expiry_action_sel  <= `WDT_ACT_RESET;
    end else if (hit) begin
      timeout_period_sel <= reg_wdata[`TIMEOUT_PERIOD_SEL_HI:`TIMEOUT_PERIOD_SEL_LO];
      expiry_action_sel  <= reg_wdata[`WDT_ACT_BIT];
    end
  end

  // Run bit; guard blocks clearing but not setting
  always_ff @(posedge clk) begin
    if (srst) timer_run_bit <= factory_run;
    else if (hit) begin
      if (reg_wdata[`WDT_RUN_BIT]) timer_run_bit <= 1'b1;
      else if (!disable_guard_bit) timer_run_bit <= 1'b0;
    end
  end

  // Feed strobe lasts one cycle, then reads back zero
  always_ff @(posedge clk) begin
    if (srst) feed_strobe <= 1'b0;
    else feed_strobe <= hit && reg_wdata[`WDT_FEED_BIT];
  end

  // Reload on feed or on a changed period
  assign cfg.reload = feed_strobe ||
                      (hit && reg_wdata[`TIMEOUT_PERIOD_SEL_HI:`TIMEOUT_PERIOD_SEL_LO] != timeout_period_sel);
  assign cfg.period_sel = (hit) ? reg_wdata[`TIMEOUT_PERIOD_SEL_HI:`TIMEOUT_PERIOD_SEL_LO] : timeout_period_sel;
  assign cfg.run = timer_run_bit;

  wdt_counter #(.BASE_CYC(BASE_CYC)) u_cnt (
    .clk  (clk),
    .srst (srst),
    .cfg  (cfg)
  );

  // Reserved bits read zero regardless of what was written
  always_comb begin
    reg_rdata = 8'h00;
    if (reg_addr == `WDT_CFG_ADDR) begin
      reg_rdata[`TIMEOUT_PERIOD_SEL_HI:`TIMEOUT_PERIOD_SEL_LO] = timeout_period_sel;
      reg_rdata[`WDT_ACT_BIT]   = expiry_action_sel;
      reg_rdata[`WDT_FEED_BIT]  = feed_strobe;
      reg_rdata[`WDT_RUN_BIT]   = timer_run_bit;
      reg_rdata[`WDT_GUARD_BIT] = disable_guard_bit;
    end
  end

  assign action = expiry_action_sel ? WDT_ACT_RESET : WDT_ACT_OFF;

  // Requests registered so they are glitch free
  always_ff @(posedge clk) begin
    if (srst) begin
      power_off_req   <= 1'b0;
      power_reset_req <= 1'b0;
    end else begin
      power_off_req   <= cfg.expired && (action == WDT_ACT_OFF);
      power_reset_req <= cfg.expired && (action == WDT_ACT_RESET);
    end
  end

  property p_lock_holds;
    @(posedge clk) disable iff (srst) disable_guard_bit && timer_run_bit |=> timer_run_bit;
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("locked run bit cleared");

  property p_feed_clears;
    @(posedge clk) disable iff (srst) feed_strobe |=> !feed_strobe || $past(hit);
  endproperty
  a_feed_clears: assert property (p_feed_clears) else $error("feed did not clear");

  property p_one_req;
    @(posedge clk) disable iff (srst) !(power_off_req && power_reset_req);
  endproperty
  a_one_req: assert property (p_one_req) else $error("both requests at once");

  // Checks on the register port and the fields behind it

  // Other addresses read as zero
  property p_unmapped_zero;
    @(posedge clk) disable iff (srst) (reg_addr != `WDT_CFG_ADDR) |-> (reg_rdata == 8'h00);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped address read nonzero");

  // Reserved top bits always read zero
  property p_reserved_zero;
    @(posedge clk) disable iff (srst) reg_rdata[7:6] == 2'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read nonzero");

  // A write lands the period field
  property p_period_write;
    @(posedge clk) disable iff (srst) hit |=> timeout_period_sel == $past(reg_wdata[`TIMEOUT_PERIOD_SEL_HI:`TIMEOUT_PERIOD_SEL_LO]);
  endproperty
  a_period_write: assert property (p_period_write)
    else $error("period field not written");

  // A write lands the action bit
  property p_action_write;
    @(posedge clk) disable iff (srst) hit |=> expiry_action_sel == $past(reg_wdata[`WDT_ACT_BIT]);
  endproperty
  a_action_write: assert property (p_action_write)
    else $error("action bit not written");

  // Setting the run bit always works, guard or not
  property p_run_set;
    @(posedge clk) disable iff (srst) hit && reg_wdata[`WDT_RUN_BIT] |=> timer_run_bit;
  endproperty
  a_run_set: assert property (p_run_set)
    else $error("run bit not set");

  // Without the guard a zero write stops the timer
  property p_run_clear_free;
    @(posedge clk) disable iff (srst) hit && !reg_wdata[`WDT_RUN_BIT] && !disable_guard_bit |=> !timer_run_bit;
  endproperty
  a_run_clear_free: assert property (p_run_clear_free)
    else $error("run bit not cleared");

  // Guard bit never moves outside reset
  property p_guard_const;
    @(posedge clk) disable iff (srst) $stable(disable_guard_bit);
  endproperty
  a_guard_const: assert property (p_guard_const)
    else $error("guard bit changed");

  // A feed write raises the strobe next cycle
  property p_feed_pulse;
    @(posedge clk) disable iff (srst) hit && reg_wdata[`WDT_FEED_BIT] |=> feed_strobe;
  endproperty
  a_feed_pulse: assert property (p_feed_pulse)
    else $error("feed write lost");

  // The strobe reloads the countdown
  property p_feed_reload;
    @(posedge clk) disable iff (srst) feed_strobe |-> cfg.reload;
  endproperty
  a_feed_reload: assert property (p_feed_reload)
    else $error("feed did not reload");

  // A changed period reloads in the same edge
  property p_period_reload;
    @(posedge clk) disable iff (srst)
      hit && (reg_wdata[`TIMEOUT_PERIOD_SEL_HI:`TIMEOUT_PERIOD_SEL_LO] != timeout_period_sel) |-> cfg.reload;
  endproperty
  a_period_reload: assert property (p_period_reload)
    else $error("period change did not reload");

  // Power-off only follows an expiry with action zero
  property p_off_source;
    @(posedge clk) disable iff (srst) power_off_req |-> $past(cfg.expired) && !$past(expiry_action_sel);
  endproperty
  a_off_source: assert property (p_off_source)
    else $error("power-off without cause");

  // Power-reset only follows an expiry with action one
  property p_reset_source;
    @(posedge clk) disable iff (srst) power_reset_req |-> $past(cfg.expired) && $past(expiry_action_sel);
  endproperty
  a_reset_source: assert property (p_reset_source)
    else $error("power-reset without cause");

  // Every expiry is passed on as a request
  property p_expiry_passed;
    @(posedge clk) disable iff (srst) cfg.expired |=> power_off_req || power_reset_req;
  endproperty
  a_expiry_passed: assert property (p_expiry_passed)
    else $error("expiry dropped");

  // A stopped timer never expires
  property p_stopped_silent;
    @(posedge clk) disable iff (srst) !timer_run_bit |=> !cfg.expired;
  endproperty
  a_stopped_silent: assert property (p_stopped_silent)
    else $error("expiry while run bit clear");

  // Writes elsewhere leave the period alone
  property p_unmapped_no_effect;
    @(posedge clk) disable iff (srst) reg_wr && (reg_addr != `WDT_CFG_ADDR) |=> $stable(timeout_period_sel);
  endproperty
  a_unmapped_no_effect: assert property (p_unmapped_no_effect)
    else $error("foreign write changed period");
endmodule : wdt_top
`default_nettype wire
